//--- sst_top.sv
// Behaviour
// - mult code 0001 gives peripheral clock x4.
// - stop bit zero wakes the serial interface.
// - mode, order, clock fields locked while enabled.
// - enables set only from both-zero; clear together.
// - baud divisor readable always, writable only disabled.
// - clock source 00 drives internal shift clock.
// - transmit-end request gated by its enable.
// - transmission runs only while transmit enabled.
// - empty request gated by transmit interrupt enable.
// - prescale 00 feeds baud from peripheral clock.
// - mode bit one selects clock-synchronous operation.
// - card select zero keeps ordinary serial mode.
// - bit order zero shifts LSB first.
// - divisor 04h at 50 MHz gives 2.5 Mbps.
// - read-only end flag at status bit 2.
// - eight-bit transmit data register holds character.
//
// The implementer's own choice: the AXI4-Lite slave port.
`default_nettype none

module sst_top #(
  parameter int ACLK_HZ = 200_000_000,
  parameter int XTAL_HZ = 12_500_000
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [sst_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [sst_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link.
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n,
  output logic tx_data_o,
  // Interrupt requests to the system.
  output logic tx_empty_request,
  output logic tx_end_request
);

  localparam int DIV_X1 = ACLK_HZ / XTAL_HZ;

  if (XTAL_HZ <= 0 || ACLK_HZ % (XTAL_HZ * sst_pkg::MULT_X8) != 0 || DIV_X1 > 256) begin : g_chk
    $error("aclk must be a multiple of eight crystal periods, at most 256 of them");
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ****************************************
  // Register bus slave
  // ****************************************
  logic aw_hold_q;
  logic w_hold_q;
  logic [21:0] aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [31:0] wmask;
  logic wr_smr;
  logic wr_brr;
  logic wr_scr;
  logic wr_tdr;
  logic wr_scmr;
  logic wr_system_clock_control;
  logic wr_mstp;
  logic mapped_w;

  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign wr_fire = aw_hold_q && w_hold_q;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_mstp = wr_fire && aw_idx_q == sst_pkg::IDX_MSTP;
  assign wr_system_clock_control = wr_fire && aw_idx_q == sst_pkg::IDX_SYSTEM_CLOCK_CONTROL;
  assign wr_smr = wr_fire && wstrb_q[0] && aw_idx_q == sst_pkg::IDX_SMR;
  assign wr_brr = wr_fire && wstrb_q[0] && aw_idx_q == sst_pkg::IDX_BRR;
  assign wr_scr = wr_fire && wstrb_q[0] && aw_idx_q == sst_pkg::IDX_SCR;
  assign wr_tdr = wr_fire && wstrb_q[0] && aw_idx_q == sst_pkg::IDX_TDR;
  assign wr_scmr = wr_fire && wstrb_q[0] && aw_idx_q == sst_pkg::IDX_SCMR;

  always_comb begin
    mapped_w = 1'b1;
    if (aw_idx_q == sst_pkg::IDX_MSTP || aw_idx_q == sst_pkg::IDX_SYSTEM_CLOCK_CONTROL) begin
      mapped_w = 1'b1;
    end else if (aw_idx_q >= sst_pkg::IDX_SMR && aw_idx_q <= sst_pkg::IDX_SSR) begin
      mapped_w = 1'b1;
    end else if (aw_idx_q == sst_pkg::IDX_SCMR) begin
      mapped_w = 1'b1;
    end else begin
      mapped_w = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_idx_q <= 22'h000000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      aw_idx_q <= s_axi_awaddr[sst_pkg::AW-1:2];
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sst_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped_w ? sst_pkg::RESP_OKAY : sst_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [31:0] mstp_q;
  logic [31:0] system_clock_control_q;
  sst_pkg::sst_smr_t smr_q;
  logic [7:0] brr_q;
  sst_pkg::sst_scr_t scr_q;
  sst_pkg::sst_scr_t scr_wr;
  sst_pkg::sst_scmr_t scmr_q;
  logic [7:0] tdr_q;
  logic tdr_full_q;
  logic locked;
  logic active;
  logic [3:0] periph_clock_mult;

  assign locked = scr_q.tx_enable || scr_q.rx_enable;
  assign active = !mstp_q[sst_pkg::STOP_BIT];
  assign periph_clock_mult = system_clock_control_q[sst_pkg::PCK_LSB+3:sst_pkg::PCK_LSB];
  assign scr_wr = wdata_q[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mstp_q <= sst_pkg::MSTP_RST;
    end else if (wr_mstp) begin
      mstp_q <= (mstp_q & ~wmask) | (wdata_q & wmask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_clock_control_q <= sst_pkg::SYSTEM_CLOCK_CONTROL_RST;
    end else if (wr_system_clock_control) begin
      system_clock_control_q <= (system_clock_control_q & ~wmask) | (wdata_q & wmask);
    end
  end

  // Writes that hit a locked field are dropped silently but still answer OKAY.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smr_q <= sst_pkg::SMR_RST;
      scmr_q <= sst_pkg::SCMR_RST;
    end else if (!locked) begin
      if (wr_smr) begin
        smr_q <= wdata_q[7:0];
      end
      if (wr_scmr) begin
        scmr_q.card_mode_sel <= wdata_q[0];
        scmr_q.bit_order_sel <= wdata_q[3];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brr_q <= sst_pkg::BRR_RST;
    end else if (wr_brr && !locked) begin
      brr_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scr_q <= sst_pkg::SCR_RST;
    end else if (wr_scr) begin
      scr_q.tx_irq_enable <= scr_wr.tx_irq_enable;
      scr_q.rx_irq_enable <= scr_wr.rx_irq_enable;
      scr_q.mp_irq_enable <= scr_wr.mp_irq_enable;
      scr_q.tx_done_irq_enable <= scr_wr.tx_done_irq_enable;
      if (!locked) begin
        scr_q.clk_src <= scr_wr.clk_src;
        scr_q.tx_enable <= scr_wr.tx_enable;
        scr_q.rx_enable <= scr_wr.rx_enable;
      end else if (!scr_wr.tx_enable && !scr_wr.rx_enable) begin
        scr_q.tx_enable <= 1'b0;
        scr_q.rx_enable <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tdr_q <= sst_pkg::TDR_RST;
    end else if (wr_tdr) begin
      tdr_q <= wdata_q[7:0];
    end
  end

  // ****************************************
  // Peripheral clock and baud generator
  // ****************************************
  logic [7:0] pdiv;
  logic [7:0] pc_q;
  logic pclk_tick;
  logic [5:0] psc_lim;
  logic [5:0] psc_q;
  logic ptick;
  logic [8:0] hcnt_q;
  logic half_tick;
  sst_pkg::sst_state_t st_q;

  always_comb begin
    case (periph_clock_mult)
      sst_pkg::PCK_X8: pdiv = 8'(DIV_X1 / sst_pkg::MULT_X8 - 1);
      sst_pkg::PCK_X4: pdiv = 8'(DIV_X1 / sst_pkg::MULT_X4 - 1);
      sst_pkg::PCK_X2: pdiv = 8'(DIV_X1 / sst_pkg::MULT_X2 - 1);
      default: pdiv = 8'(DIV_X1 - 1);
    endcase
  end

  always_comb begin
    case (smr_q.clock_prescale)
      2'h0: psc_lim = 6'h00;
      2'h1: psc_lim = 6'h03;
      2'h2: psc_lim = 6'h0F;
      default: psc_lim = 6'h3F;
    endcase
  end

  assign pclk_tick = active && pc_q == pdiv;
  assign ptick = pclk_tick && psc_q == psc_lim;
  assign half_tick = ptick && hcnt_q == {brr_q, 1'b1};

  // The module clock is gated off while stopped, so the divider restarts cleanly.
  always_ff @(posedge aclk) begin
    if (!aresetn || !active || wr_system_clock_control) begin
      pc_q <= 8'h00;
    end else if (pclk_tick) begin
      pc_q <= 8'h00;
    end else begin
      pc_q <= pc_q + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || st_q != sst_pkg::ST_SHIFT) begin
      psc_q <= 6'h00;
      hcnt_q <= 9'h000;
    end else if (pclk_tick) begin
      psc_q <= (psc_q == psc_lim) ? 6'h00 : psc_q + 6'h01;
      if (ptick) begin
        hcnt_q <= half_tick ? 9'h000 : hcnt_q + 9'h001;
      end
    end
  end

  // ****************************************
  // Transmit shifter
  // ****************************************
  logic tx_ok;
  logic load;
  logic sck_q;
  logic txd_q;
  logic [7:0] shreg_q;
  logic [2:0] bit_cnt_q;
  logic next_bit;
  logic tx_complete_flag;
  logic rise_now;
  logic done;

  // Only clock-synchronous, internally clocked, ordinary mode is served.
  assign tx_ok = active && scr_q.tx_enable
    && smr_q.comm_mode_bit
    && !scmr_q.card_mode_sel
    && scr_q.clk_src == sst_pkg::CLK_SRC_INT;
  assign load = tx_ok && st_q == sst_pkg::ST_IDLE && tdr_full_q;
  assign next_bit = scmr_q.bit_order_sel ? shreg_q[3'h7 - bit_cnt_q]
                                         : shreg_q[bit_cnt_q];
  assign rise_now = st_q == sst_pkg::ST_SHIFT && half_tick && !sck_q;
  assign done = rise_now && bit_cnt_q == 3'h7;
  assign tx_complete_flag = st_q == sst_pkg::ST_IDLE && !tdr_full_q;

  // A character in flight is abandoned at once when the link is disabled.
  always_ff @(posedge aclk) begin
    if (!aresetn || !tx_ok) begin
      st_q <= sst_pkg::ST_IDLE;
      sck_q <= 1'b1;
      bit_cnt_q <= 3'h0;
    end else begin
      case (st_q)
        sst_pkg::ST_IDLE: begin
          if (load) begin
            st_q <= sst_pkg::ST_SHIFT;
            bit_cnt_q <= 3'h0;
          end
        end
        sst_pkg::ST_SHIFT: begin
          if (half_tick && sck_q) begin
            sck_q <= 1'b0;
          end else if (rise_now) begin
            sck_q <= 1'b1;
            if (done) begin
              st_q <= sst_pkg::ST_IDLE;
            end else begin
              bit_cnt_q <= bit_cnt_q + 3'h1;
            end
          end
        end
        default: st_q <= sst_pkg::ST_IDLE;
      endcase
    end
  end

  // Data changes on the falling edge so the far end samples a settled bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg_q <= 8'h00;
      txd_q <= 1'b1;
    end else if (load) begin
      shreg_q <= tdr_q;
      txd_q <= scmr_q.bit_order_sel ? tdr_q[7] : tdr_q[0];
    end else if (st_q == sst_pkg::ST_SHIFT && half_tick && sck_q && bit_cnt_q != 3'h0) begin
      txd_q <= next_bit;
    end
  end

  // A write in the cycle of a load refills the register: the set wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tdr_full_q <= 1'b0;
    end else if (wr_tdr) begin
      tdr_full_q <= 1'b1;
    end else if (load) begin
      tdr_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_empty_request <= 1'b0;
      tx_end_request <= 1'b0;
    end else begin
      tx_empty_request <= scr_q.tx_irq_enable && scr_q.tx_enable && !tdr_full_q;
      tx_end_request <= scr_q.tx_done_irq_enable && scr_q.tx_enable && tx_complete_flag;
    end
  end

  assign serial_clock_pin_o = sck_q;
  assign serial_clock_pin_oe_n = !(active && smr_q.comm_mode_bit
    && scr_q.clk_src == sst_pkg::CLK_SRC_INT);
  assign tx_data_o = txd_q;

  // ****************************************
  // Register read path
  // ****************************************
  logic [21:0] ar_idx;
  logic [31:0] rd_mux;
  logic rd_hit;

  assign ar_idx = s_axi_araddr[sst_pkg::AW-1:2];
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    if (ar_idx == sst_pkg::IDX_MSTP) begin
      rd_mux = mstp_q;
    end else if (ar_idx == sst_pkg::IDX_SYSTEM_CLOCK_CONTROL) begin
      rd_mux = system_clock_control_q;
    end else if (ar_idx == sst_pkg::IDX_SMR) begin
      rd_mux = {24'h000000, smr_q};
    end else if (ar_idx == sst_pkg::IDX_BRR) begin
      rd_mux = {24'h000000, brr_q};
    end else if (ar_idx == sst_pkg::IDX_SCR) begin
      rd_mux = {24'h000000, scr_q};
    end else if (ar_idx == sst_pkg::IDX_TDR) begin
      rd_mux = {24'h000000, tdr_q};
    end else if (ar_idx == sst_pkg::IDX_SSR) begin
      rd_mux[sst_pkg::TX_COMPLETE_FLAG_BIT] = tx_complete_flag;
    end else if (ar_idx == sst_pkg::IDX_SCMR) begin
      rd_mux = {24'h000000, scmr_q};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= sst_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? sst_pkg::RESP_OKAY : sst_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [3:0] pulses_q;
  logic dflt;
  logic [6:0] low_q;

  // A 39-deep repetition would be unrolled by the tools, so the low half is counted here.
  localparam logic [6:0] HALF_BIT_CYC = 7'h28;

  assign dflt = ACLK_HZ == 200_000_000 && XTAL_HZ == 12_500_000;

  always_ff @(posedge aclk) begin
    if (!aresetn || load) begin
      pulses_q <= 4'h0;
    end else if (rise_now) begin
      pulses_q <= pulses_q + 4'h1;
    end
  end

  sequence s_pclk_x4;
    !pclk_tick [*3] ##1 pclk_tick;
  endsequence

  always_ff @(posedge aclk) begin
    if (!aresetn || sck_q) begin
      low_q <= 7'h00;
    end else if (low_q != 7'h7F) begin
      low_q <= low_q + 7'h01;
    end
  end

  AST_PCLK_X4: assert property (disable iff (!aresetn || wr_system_clock_control || !active)
    dflt && pclk_tick && periph_clock_mult == sst_pkg::PCK_X4 |=> s_pclk_x4)
    else $error("peripheral clock tick is not every four cycles");

  AST_STOP_WAKE: assert property (
    wr_mstp && wstrb_q[3] && !wdata_q[sst_pkg::STOP_BIT] |=> active ##0 !pc_q[7])
    else $error("clearing the stop bit did not wake the interface");

  AST_MODE_LOCK: assert property (
    locked && (wr_smr || wr_scmr) |=> $stable(smr_q) && $stable(scmr_q))
    else $error("mode or order changed while enabled");

  AST_EN_LOCK: assert property (
    locked && wr_scr |=> {scr_q.tx_enable, scr_q.rx_enable} == 2'h0
      || {scr_q.tx_enable, scr_q.rx_enable} == $past({scr_q.tx_enable, scr_q.rx_enable}))
    else $error("enable bits changed illegally");

  AST_BRR_LOCK: assert property (
    locked && wr_brr |=> brr_q == $past(brr_q))
    else $error("baud divisor written while enabled");

  AST_SCK_OWN: assert property (
    st_q == sst_pkg::ST_SHIFT && tx_ok |-> !serial_clock_pin_oe_n && scr_q.clk_src == 2'h0)
    else $error("shifting without driving the internal clock");

  AST_TEI_GATE: assert property (
    tx_end_request |-> $past(scr_q.tx_done_irq_enable) && $past(tx_complete_flag))
    else $error("transmit end request while disabled");

  AST_TX_OFF: assert property (
    !scr_q.tx_enable |=> st_q == sst_pkg::ST_IDLE && serial_clock_pin_o)
    else $error("transmitter ran while disabled");

  AST_TXI_GATE: assert property (
    tx_empty_request |-> $past(scr_q.tx_irq_enable) && !$past(tdr_full_q))
    else $error("empty request while masked or full");

  AST_BIT_RATE: assert property (disable iff (!aresetn || !tx_ok || wr_mstp)
    dflt && $rose(sck_q) && brr_q == 8'h04 && smr_q.clock_prescale == 2'h0
      && periph_clock_mult == sst_pkg::PCK_X4 |-> low_q == HALF_BIT_CYC)
    else $error("half bit period is not forty cycles");

  AST_SYNC_ONLY: assert property (
    !smr_q.comm_mode_bit || scmr_q.card_mode_sel |=> st_q == sst_pkg::ST_IDLE)
    else $error("shifting outside ordinary synchronous mode");

  AST_LSB_FIRST: assert property (
    $rose(sck_q) && !scmr_q.bit_order_sel |-> tx_data_o == shreg_q[$past(bit_cnt_q)])
    else $error("bit on the line is not in LSB-first order");

  AST_TX_COMPLETE_FLAG_BUSY: assert property (
    load |=> !tx_complete_flag ##0 st_q == sst_pkg::ST_SHIFT)
    else $error("end flag set while a character is in flight");

  AST_TDR_HOLD: assert property (
    wr_tdr |=> tdr_q == $past(wdata_q[7:0]) && tdr_full_q)
    else $error("transmit data not held after write");

  AST_EIGHT_PULSES: assert property (
    done |=> pulses_q == sst_pkg::BITS_PER_CHAR && sck_q)
    else $error("character did not give eight clock pulses");

endmodule : sst_top

`default_nettype wire

//--- sst_pkg.sv
`default_nettype none

package sst_pkg;

  // ****************************************
  // Bus geometry and register indices
  // ****************************************
  localparam int AW = 24;
  localparam logic [21:0] IDX_MSTP = 22'h080014;
  localparam logic [21:0] IDX_SYSTEM_CLOCK_CONTROL = 22'h080020;
  localparam logic [21:0] IDX_SMR = 22'h088240;
  localparam logic [21:0] IDX_BRR = 22'h088241;
  localparam logic [21:0] IDX_SCR = 22'h088242;
  localparam logic [21:0] IDX_TDR = 22'h088243;
  localparam logic [21:0] IDX_SSR = 22'h088244;
  localparam logic [21:0] IDX_SCMR = 22'h088246;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int STOP_BIT = 31;
  localparam int PCK_LSB = 8;
  localparam int TX_COMPLETE_FLAG_BIT = 2;
  localparam logic [31:0] MSTP_RST = 32'hFFFFFFFF;
  localparam logic [31:0] SYSTEM_CLOCK_CONTROL_RST = 32'h00000100;
  localparam logic [7:0] SMR_RST = 8'h00;
  localparam logic [7:0] BRR_RST = 8'hFF;
  localparam logic [7:0] SCR_RST = 8'h00;
  localparam logic [7:0] TDR_RST = 8'hFF;
  localparam logic [7:0] SCMR_RST = 8'h00;

  // ****************************************
  // Encodings and multipliers
  // ****************************************
  localparam logic [3:0] PCK_X8 = 4'h0;
  localparam logic [3:0] PCK_X4 = 4'h1;
  localparam logic [3:0] PCK_X2 = 4'h2;
  localparam int MULT_X8 = 8;
  localparam int MULT_X4 = 4;
  localparam int MULT_X2 = 2;
  localparam logic [1:0] CLK_SRC_INT = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] BITS_PER_CHAR = 4'h8;

  // ****************************************
  // Register layouts
  // ****************************************
  typedef struct packed {
    logic tx_irq_enable;
    logic rx_irq_enable;
    logic tx_enable;
    logic rx_enable;
    logic mp_irq_enable;
    logic tx_done_irq_enable;
    logic [1:0] clk_src;
  } sst_scr_t;

  typedef struct packed {
    logic comm_mode_bit;
    logic [4:0] fmt;
    logic [1:0] clock_prescale;
  } sst_smr_t;

  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic bit_order_sel;
    logic [1:0] rsvd_lo;
    logic card_mode_sel;
  } sst_scmr_t;

  typedef enum logic {ST_IDLE, ST_SHIFT} sst_state_t;

endpackage : sst_pkg

`default_nettype wire

//--- sst_rx_model.sv
`default_nettype none

// ****************************************
// Far receiver, clocked by aclk and sampling rises of the shift clock
// ****************************************
module sst_rx_model (
  // Local clock and link.
  input wire logic aclk,
  input wire logic sck,
  input wire logic sck_oe_n,
  input wire logic sd,
  // Received characters.
  output logic [7:0] rx_byte,
  output var int rx_count,
  output var int bit_period
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh = 8'h00;
  logic [2:0] n = 3'h0;
  logic sck_q = 1'b1;
  int cyc = 0;
  int last = 0;

  initial rx_count = 0;
  initial bit_period = 0;

  // Data stands a whole half period after the rise, so sampling one cycle late is safe.
  always @(posedge aclk) begin
    sck_q <= sck;
    cyc <= cyc + 1;
    if (!sck_oe_n && sck && !sck_q) begin
      sh <= {sd, sh[7:1]};
      n <= n + 3'h1;
      bit_period <= cyc - last;
      last <= cyc;
      if (n == 3'h7) begin
        rx_byte <= {sd, sh[7:1]};
        rx_count <= rx_count + 1;
      end
    end
  end
endmodule : sst_rx_model

`default_nettype wire

//--- testbench.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn;
  logic [sst_pkg::AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic serial_clock_pin_o, serial_clock_pin_oe_n, tx_data_o, tx_empty_request, tx_end_request;
  logic [7:0] rx_byte;
  int rx_count, bit_period;
  int n_mismatch = 0;
  int total_checks = 0;

  sst_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_clock_pin_o, .serial_clock_pin_oe_n,
    .tx_data_o, .tx_empty_request, .tx_end_request);
  sst_rx_model i_far (.aclk, .sck(serial_clock_pin_o), .sck_oe_n(serial_clock_pin_oe_n),
    .sd(tx_data_o), .rx_byte, .rx_count, .bit_period);

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic hang;
    n_mismatch++;
    wrap_up();
  endtask : hang

  // Ready is sampled on the falling edge so the handshake never races the rising edge.
  task automatic wr(input logic [21:0] i, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic a, w, b;
    int k;
    b = 1'b0;
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 64 && !b; k++) begin
      @(negedge aclk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      if (b) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    @(posedge aclk);
    if (!b) hang();
  endtask : wr

  task automatic rd(input logic [21:0] i, input logic [1:0] er = 2'h0);
    logic a, r;
    int k;
    r = 1'b0;
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 64 && !r; k++) begin
      @(negedge aclk);
      a = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      v = s_axi_rdata;
      if (r) chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
    end
    @(posedge aclk);
    if (!r) hang();
  endtask : rd

  task automatic rdc(input logic [21:0] i, input logic [31:0] e, input string nm);
    rd(i);
    chk(nm, v, e);
  endtask : rdc

  task automatic wait_rx(input int c);
    int k;
    for (k = 0; k < 3000 && rx_count < c; k++) @(posedge aclk);
    if (rx_count < c) hang();
  endtask : wait_rx

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rdc(sst_pkg::IDX_BRR, 32'h000000FF, "divisor at reset");
    rd(sst_pkg::IDX_SSR);
    chk("end flag idle", {31'h0, v[2]}, 32'h1);
    rd(22'h3FFFFF, 2'h2);
    chk("unmapped data", v, 32'h0);
    wr(22'h3FFFFF, 32'h0, 2'h2);
    chk("stopped clock drive", {31'h0, serial_clock_pin_oe_n}, 32'h1);
  endtask : t_reset

  task automatic t_config;
    wr(sst_pkg::IDX_SYSTEM_CLOCK_CONTROL, 32'h00000100);
    rdc(sst_pkg::IDX_SYSTEM_CLOCK_CONTROL, 32'h00000100, "clock mult");
    wr(sst_pkg::IDX_MSTP, 32'h7FFFFFFF);
    chk("clock drive off", {31'h0, serial_clock_pin_oe_n}, 32'h1);
    wr(sst_pkg::IDX_SMR, 32'h00000080);
    wr(sst_pkg::IDX_SCMR, 32'h0);
    wr(sst_pkg::IDX_BRR, 32'h00000004);
    wr(sst_pkg::IDX_SCR, 32'h000000A0);
    rdc(sst_pkg::IDX_SCR, 32'h000000A0, "control");
    chk("clock drive on", {31'h0, serial_clock_pin_oe_n}, 32'h0);
    chk("empty request", {31'h0, tx_empty_request}, 32'h1);
  endtask : t_config

  task automatic t_lock;
    wr(sst_pkg::IDX_BRR, 32'h00000010);
    rdc(sst_pkg::IDX_BRR, 32'h00000004, "divisor locked");
    wr(sst_pkg::IDX_SMR, 32'h0);
    rdc(sst_pkg::IDX_SMR, 32'h00000080, "mode locked");
    wr(sst_pkg::IDX_SCMR, 32'h00000008);
    rdc(sst_pkg::IDX_SCMR, 32'h0, "order locked");
    wr(sst_pkg::IDX_SCR, 32'h000000B3);
    rdc(sst_pkg::IDX_SCR, 32'h000000A0, "enable and source locked");
    wr(sst_pkg::IDX_SSR, 32'h0);
    rd(sst_pkg::IDX_SSR);
    chk("status read only", {31'h0, v[2]}, 32'h1);
  endtask : t_lock

  task automatic t_tx;
    wr(sst_pkg::IDX_TDR, 32'h000000A5);
    rd(sst_pkg::IDX_SSR);
    chk("end flag busy", {31'h0, v[2]}, 32'h0);
    rdc(sst_pkg::IDX_TDR, 32'h000000A5, "data reg");
    wr(sst_pkg::IDX_TDR, 32'h0000003C);
    wait_rx(1);
    chk("first char", {24'h0, rx_byte}, 32'h000000A5);
    wait_rx(2);
    chk("second char", {24'h0, rx_byte}, 32'h0000003C);
    chk("bit period", bit_period, 32'h50);
    rd(sst_pkg::IDX_SSR);
    chk("end flag done", {31'h0, v[2]}, 32'h1);
    chk("end request masked", {31'h0, tx_end_request}, 32'h0);
    wr(sst_pkg::IDX_SCR, 32'h000000A4);
    repeat (2) @(posedge aclk);
    chk("end request", {31'h0, tx_end_request}, 32'h1);
  endtask : t_tx

  task automatic t_stop;
    wr(sst_pkg::IDX_SCR, 32'h0);
    chk("clock idle", {31'h0, serial_clock_pin_o}, 32'h1);
    chk("empty request off", {31'h0, tx_empty_request}, 32'h0);
    wr(sst_pkg::IDX_BRR, 32'h00000010);
    rdc(sst_pkg::IDX_BRR, 32'h00000010, "divisor open");
    wr(sst_pkg::IDX_SMR, 32'h0);
    rdc(sst_pkg::IDX_SMR, 32'h0, "mode open");
    chk("drive released", {31'h0, serial_clock_pin_oe_n}, 32'h1);
    wr(sst_pkg::IDX_SCMR, 32'h00000008);
    wr(sst_pkg::IDX_SMR, 32'h00000080);
    wr(sst_pkg::IDX_SCR, 32'h00000020);
    wr(sst_pkg::IDX_TDR, 32'h00000001);
    wait_rx(3);
    chk("msb first", {24'h0, rx_byte}, 32'h00000080);
  endtask : t_stop

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_config();
    t_lock();
    t_tx();
    t_stop();
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
